// ==== logic/ppdh_pkg.sv ====
// package for the pin power-down hold block
// assumes a single 10 MHz reference clock
package ppdh_pkg;
    localparam int unsigned PIN_W         = 8;
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned WAKE_MAX_US   = 1;
    localparam int unsigned WAKE_CYC_RAW  = (WAKE_MAX_US * 1000) / CLK_PERIOD_NS;
    // longest time rounds down, never below one cycle
    localparam int unsigned WAKE_CYC      = (WAKE_CYC_RAW < 1) ? 1 : WAKE_CYC_RAW;
    localparam int unsigned WAKE_CNT_W    = 5;
    localparam int unsigned WAKE_SYNC_CYC = 2;
    // two sync stages, sleep to wake, wake to run, first registering edge
    localparam int unsigned WAKE_OVH_CYC  = WAKE_SYNC_CYC + 3;
    localparam logic [WAKE_CNT_W-1:0] WAKE_LAST = WAKE_CNT_W'(WAKE_CYC - WAKE_OVH_CYC);
    // cycles from synced release to run, one edge kept for new data
    localparam logic [WAKE_CNT_W-1:0] WAKE_AGE_MAX = WAKE_CNT_W'(WAKE_CYC - WAKE_SYNC_CYC - 1);

    typedef enum {ST_RUN, ST_SLEEP, ST_WAKE} ppdh_state_e;

    typedef struct packed {
        logic [PIN_W-1:0] data;
        logic [PIN_W-1:0] oe;
    } ppdh_out_s;
endpackage

// ==== logic/ppdh_sync.sv ====
// two-flop synchroniser vector
// assumes inputs asynchronous to i_ref_clk
`timescale 1ns/1ns
module ppdh_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         i_ref_clk, // reference clock
    input  wire logic         i_rst,     // async reset, high
    input  wire logic [W-1:0] i_d,       // async input
    output logic      [W-1:0] o_q        // synchronised output
);
    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            meta_r <= '0;
            q_r    <= '0;
        end
        else
        begin
            meta_r <= i_d;
            q_r    <= meta_r;
        end
    end

    assign o_q = q_r;
endmodule // ppdh_sync

// ==== logic/ppdh_top.sv ====
// pin-controlled power-down hold around a small user logic slice
// assumes system logic drives the sleep request pin asynchronously
// Summary of operation
// - sleep pin acts only when option set
// - outputs and internal state held asleep
// - high-z outputs stay high-z asleep
// - all inputs but sleep pin ignored
// - pin hold latches keep pins defined
// - sleep pin not a logic input
// - valid again within 1 us wake
`timescale 1ns/1ns
module ppdh_top (
    input  wire logic                      i_ref_clk,     // 10 MHz clock
    input  wire logic                      i_rst,         // async reset, high
    input  wire logic                      i_sleep_en,    // config: power-down option
    input  wire logic                      i_sleep_request_pin, // power-down request
    input  wire logic [ppdh_pkg::PIN_W-1:0] i_pin,        // user input pins
    input  wire logic [ppdh_pkg::PIN_W-1:0] i_user_oe,    // user output enables
    output logic      [ppdh_pkg::PIN_W-1:0] o_pin,        // user output data
    output logic      [ppdh_pkg::PIN_W-1:0] o_pin_oe,     // user output enables
    output logic      [ppdh_pkg::PIN_W-1:0] o_pin_hold,   // held input levels
    output logic                           o_asleep       // in power-down
);
    // ************************************************************
    // input synchronisers
    // ************************************************************
    logic [ppdh_pkg::PIN_W:0]   sync_q;
    logic [ppdh_pkg::PIN_W-1:0] pin_s;
    logic [ppdh_pkg::PIN_W-1:0] oe_s;
    logic                       req_s;

    ppdh_sync #(.W(ppdh_pkg::PIN_W + 1)) u_sync_a (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_d       ({i_sleep_request_pin, i_pin}),
        .o_q       (sync_q)
    );
    ppdh_sync #(.W(ppdh_pkg::PIN_W)) u_sync_b (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_d       (i_user_oe),
        .o_q       (oe_s)
    );
    assign pin_s = sync_q[ppdh_pkg::PIN_W-1:0];
    assign req_s = sync_q[ppdh_pkg::PIN_W];

    // ************************************************************
    // power-down sequencer
    // ************************************************************
    ppdh_pkg::ppdh_state_e             state_r, state_nxt;
    logic [ppdh_pkg::WAKE_CNT_W-1:0]   wake_r, wake_nxt;
    logic                              sleep_en_r, sleep_en_nxt;
    logic                              sleep_req;
    logic                              run;

    assign sleep_req = sleep_en_r && req_s;

    always_comb
    begin
        state_nxt    = state_r;
        wake_nxt     = wake_r;
        sleep_en_nxt = sleep_en_r;
        case (state_r)
            ppdh_pkg::ST_RUN:
            begin
                sleep_en_nxt = i_sleep_en;
                if (sleep_req)
                    state_nxt = ppdh_pkg::ST_SLEEP;
            end
            ppdh_pkg::ST_SLEEP:
            begin
                if (!sleep_req)
                begin
                    state_nxt = ppdh_pkg::ST_WAKE;
                    wake_nxt  = '0;
                end
            end
            ppdh_pkg::ST_WAKE:
            begin
                if (sleep_req)
                    state_nxt = ppdh_pkg::ST_SLEEP;
                else if (wake_r >= ppdh_pkg::WAKE_LAST)
                    state_nxt = ppdh_pkg::ST_RUN;
                else
                    wake_nxt = wake_r + 1'b1;
            end
            default:
                state_nxt = ppdh_pkg::ST_RUN;
        endcase
    end

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_r    <= ppdh_pkg::ST_RUN;
            wake_r     <= '0;
            sleep_en_r <= 1'b0;
        end
        else
        begin
            state_r    <= state_nxt;
            wake_r     <= wake_nxt;
            sleep_en_r <= sleep_en_nxt;
        end
    end

    // run only when fully awake and no request pending
    assign run = (state_r == ppdh_pkg::ST_RUN) && !sleep_req;

    // ************************************************************
    // user logic slice, frozen while asleep
    // ************************************************************
    logic [ppdh_pkg::PIN_W-1:0] cnt_r, cnt_nxt;
    logic [ppdh_pkg::PIN_W-1:0] hold_r, hold_nxt;
    ppdh_pkg::ppdh_out_s        out_r, out_nxt;
    logic                       asleep_r, asleep_nxt;

    always_comb
    begin
        cnt_nxt    = cnt_r;
        hold_nxt   = hold_r;
        out_nxt    = out_r;
        asleep_nxt = (state_nxt != ppdh_pkg::ST_RUN);
        if (run)
        begin
            hold_nxt     = pin_s;
            cnt_nxt      = cnt_r + 1'b1;
            out_nxt.data = cnt_r ^ pin_s;
            out_nxt.oe   = oe_s;
        end
        // otherwise inputs are blocked and counter, pin hold and output state held
    end

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cnt_r    <= '0;
            hold_r   <= '0;
            out_r    <= '0;
            asleep_r <= 1'b0;
        end
        else
        begin
            cnt_r    <= cnt_nxt;
            hold_r   <= hold_nxt;
            out_r    <= out_nxt;
            asleep_r <= asleep_nxt;
        end
    end

    assign o_pin      = out_r.data;
    assign o_pin_oe   = out_r.oe;
    assign o_pin_hold = hold_r;
    assign o_asleep   = asleep_r;

    // ************************************************************
    // wake time helper for checks
    // ************************************************************
    logic [ppdh_pkg::WAKE_CNT_W-1:0] wake_age_r, wake_age_nxt;

    // cycles since the synced request fell, cleared in run or on new request
    always_comb
    begin
        wake_age_nxt = '0;
        if (state_r != ppdh_pkg::ST_RUN && !sleep_req)
            wake_age_nxt = wake_age_r + 1'b1;
    end

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            wake_age_r <= '0;
        else
            wake_age_r <= wake_age_nxt;
    end

    // ************************************************************
    // checks
    // ************************************************************
    sequence s_asleep;
        state_r == ppdh_pkg::ST_SLEEP;
    endsequence
    sequence s_released;
        state_r == ppdh_pkg::ST_SLEEP && !sleep_req;
    endsequence

    a_opt_gates_sleep: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (state_r == ppdh_pkg::ST_RUN && !sleep_en_r) |=> state_r != ppdh_pkg::ST_SLEEP)
        else $error("sleep entered with option off");
    a_sleep_taken: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (state_r == ppdh_pkg::ST_RUN && sleep_req) |=> s_asleep ##0 asleep_r)
        else $error("sleep request not taken");
    a_outputs_held: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_asleep |=> $stable(out_r.data))
        else $error("output data moved while asleep");
    a_hiz_kept: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_asleep |=> $stable(out_r.oe))
        else $error("output enable moved while asleep");
    a_inputs_blocked: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (state_r != ppdh_pkg::ST_RUN) |=> $stable(cnt_r))
        else $error("internal state moved while not running");
    a_option_frozen: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (state_r != ppdh_pkg::ST_RUN) |=> $stable(sleep_en_r))
        else $error("option register moved while not running");
    a_hold_latch: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (!run) |=> $stable(hold_r))
        else $error("pin hold changed while blocked");
    a_hold_follows: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        run |=> hold_r == $past(pin_s))
        else $error("pin hold not following inputs");
    a_pin_not_logic: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        run |=> out_r.data == ($past(cnt_r) ^ $past(pin_s)))
        else $error("output not from user inputs");
    a_wake_bound: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_released ##1 (!sleep_req) [*6] |-> ##[0:1] state_r == ppdh_pkg::ST_RUN)
        else $error("wake took longer than 1 us");
    a_wake_count: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        wake_age_r <= ppdh_pkg::WAKE_AGE_MAX)
        else $error("wake time passed its bound");
    a_resume_held: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (state_r == ppdh_pkg::ST_WAKE && state_nxt == ppdh_pkg::ST_RUN) ##1 run
            |=> cnt_r == $past(cnt_r, 2) + 8'h01)
        else $error("state lost on wake");
endmodule // ppdh_top

// ==== tb/ppdh_sleep_driver.sv ====
// partner model: system logic driving the sleep request pin
// assumes the bench commands sleep by level on i_want_sleep
`timescale 1ns/1ns
module ppdh_sleep_driver #(
    parameter int unsigned LAG = 2
) (
    input  wire logic i_ref_clk,          // 10 MHz clock
    input  wire logic i_want_sleep,       // bench command
    output logic      o_sleep_request_pin // request pin level
);
    logic [7:0] hist_r = 8'h00;
    always @(posedge i_ref_clk)
    begin
        hist_r <= {hist_r[6:0], i_want_sleep};
    end
    // slow answer: pin follows the command LAG cycles late
    assign o_sleep_request_pin = (LAG == 0) ? i_want_sleep : hist_r[(LAG == 0) ? 0 : LAG - 1];
endmodule // ppdh_sleep_driver

// ==== tb/ppdh_top_tb_top.sv ====
// testbench for the pin power-down hold block
// assumes one 10 MHz clock and reset held 5 cycles
`timescale 1ns/1ns
`define CHK(a, b) \
    begin \
        samples_checked++; \
        if ((a) !== (b)) \
        begin \
            fails++; \
            $display("BAD %0t mismatch got %h want %h", $time, a, b); \
        end \
    end
module ppdh_top_tb_top;
    logic                       i_ref_clk  = 1'b0;
    logic                       i_rst      = 1'b1;
    logic                       i_sleep_en = 1'b0;
    logic                       want_sleep = 1'b0;
    logic                       req_pin;
    logic [ppdh_pkg::PIN_W-1:0] i_pin      = 8'h00;
    logic [ppdh_pkg::PIN_W-1:0] i_user_oe  = 8'h00;
    logic [ppdh_pkg::PIN_W-1:0] o_pin;
    logic [ppdh_pkg::PIN_W-1:0] o_pin_oe;
    logic [ppdh_pkg::PIN_W-1:0] o_pin_hold;
    logic                       o_asleep;
    int                         fails = 0;
    int                         samples_checked = 0;
    always #50 i_ref_clk = ~i_ref_clk;
    ppdh_sleep_driver #(.LAG(2)) ppdh_sleep_driver_i (.i_ref_clk(i_ref_clk),
        .i_want_sleep(want_sleep), .o_sleep_request_pin(req_pin));
    ppdh_top ppdh_top_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_sleep_en(i_sleep_en),
        .i_sleep_request_pin(req_pin), .i_pin(i_pin), .i_user_oe(i_user_oe),
        .o_pin(o_pin), .o_pin_oe(o_pin_oe), .o_pin_hold(o_pin_hold), .o_asleep(o_asleep));
    // ****************************************
    // scenario tasks
    // ****************************************
    task automatic step(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask
    task automatic finish_test;
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic t_option_off;
        i_sleep_en = 1'b0;
        i_user_oe  = 8'h5a;
        want_sleep = 1'b1;
        repeat (12)
        begin
            step(1);
            `CHK(o_asleep, 1'b0)
        end
        `CHK(o_pin_oe, 8'h5a)
        want_sleep = 1'b0;
        step(4);
    endtask
    task automatic t_sleep_hold;
        ppdh_pkg::ppdh_out_s snap;
        logic [7:0]          hold;
        int                  n;
        i_sleep_en = 1'b1;
        i_pin      = 8'ha5;
        i_user_oe  = 8'h0f;
        step(4);
        `CHK(o_pin_hold, 8'ha5)
        want_sleep = 1'b1;
        n = 0;
        while (o_asleep !== 1'b1 && n < 8)
        begin
            step(1);
            n++;
        end
        `CHK(o_asleep, 1'b1)
        snap = '{data: o_pin, oe: o_pin_oe};
        hold = o_pin_hold;
        i_pin      = 8'h3c;
        i_user_oe  = 8'hff;
        repeat (8)
        begin
            step(1);
            `CHK(o_pin, snap.data)
            `CHK(o_pin_oe, 8'h0f)
            `CHK(o_pin_hold, hold)
        end
    endtask
    task automatic t_wake;
        int  n;
        time t0;
        want_sleep = 1'b0;
        @(negedge req_pin);
        t0 = $time;
        n = 0;
        while (o_asleep !== 1'b0 && n < 30)
        begin
            step(1);
            n++;
        end
        `CHK(($time - t0) <= ppdh_pkg::WAKE_MAX_US * 1000, 1'b1)
        step(1);
        `CHK(o_pin_oe, 8'hff)
        step(2);
        `CHK(o_pin_hold, 8'h3c)
        `CHK(o_pin_oe, 8'hff)
    endtask
    initial
    begin
        step(5);
        i_rst = 1'b0;
        step(2);
        t_option_off();
        t_sleep_hold();
        t_wake();
        finish_test();
    end
    initial
    begin
        #50000;
        fails++;
        finish_test();
    end
endmodule // ppdh_top_tb_top
